// ---- axis_stop_pkg.sv ----
// constants and carrier types for the per-axis stop and limit input block
// assumes one reference clock domain; all sensor pins arrive asynchronously
// How it works
// - emergency stop low blocks every start
// - emergency stop low halts moving axes instantly
// - strap low: limits active high, else low
// - positive limit stops positive feed as configured
// - negative limit stops negative feed as configured
// - slowdown input level or latched, decelerates
// - origin acted on detected edge only
// - alarm stops axis, instant or decelerating
// - software selects slowdown, origin, alarm polarity
// - sensor states readable as sub status
// - shared active-low group start line
// - shared active-low group stop line
// - group lines readable as extension status
package axis_stop_pkg;
    localparam int num_axes = 4;
    localparam int addr_w = 4;
    localparam int data_w = 32;
    // register map, one word per index
    localparam logic [addr_w-1:0] reg_polarity = 4'h0;
    localparam logic [addr_w-1:0] reg_mode = 4'h1;
    localparam logic [addr_w-1:0] reg_sub_status = 4'h2;
    localparam logic [addr_w-1:0] reg_ext_status = 4'h3;
    localparam logic [addr_w-1:0] reg_irq_status = 4'h4;
    localparam logic [addr_w-1:0] reg_irq_mask = 4'h5;
    localparam logic [addr_w-1:0] reg_group_ctrl = 4'h6;
    // polarity register: per axis 4 bits, slowdown/origin/alarm invert
    localparam int pol_sd_bit = 0;
    localparam int pol_org_bit = 1;
    localparam int pol_alm_bit = 2;
    localparam int pol_stride = 4;
    // mode register: per axis 4 bits
    localparam int mode_sd_latch_bit = 0;
    localparam int mode_el_decel_bit = 1;
    localparam int mode_alm_decel_bit = 2;
    localparam int mode_stride = 4;
    // sub status per axis: pel, nel, sd, org, alm, moving
    localparam int sub_stride = 8;
    // interrupt event bits
    localparam int irq_emg_bit = 0;
    localparam int irq_group_stop_bit = 1;
    localparam int irq_org_base = 4;
    localparam int irq_stop_base = 8;
    localparam int irq_w = 12;
    // group control bits
    localparam int grp_start_bit = 0;
    localparam int grp_stop_bit = 1;
    localparam logic [data_w-1:0] reset_zero = 32'h0000_0000;

    typedef struct packed {
        logic pos_end_limit_in;
        logic neg_end_limit_in;
        logic slowdown_in;
        logic origin_in;
        logic alarm_in;
    } axis_pins_t;

    typedef struct packed {
        logic start_req;
        logic dir_neg;
    } axis_cmd_t;

    typedef struct packed {
        logic moving;
        logic stop_now;
        logic decel;
        logic origin_edge;
    } axis_state_t;
endpackage : axis_stop_pkg

// ---- axis_limit_stop_inputs.sv ----
// stop, limit and group start/stop handling for all axes
// assumes pins asynchronous, motion core on core_clk consumes stop/decel flags
`timescale 1ns/10ps
module axis_limit_stop_inputs #(
    parameter int sync_stages = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire axis_stop_pkg::axis_pins_t [axis_stop_pkg::num_axes-1:0] axis_pins,
    input wire logic [axis_stop_pkg::num_axes-1:0] limit_polarity_strap,
    input wire logic emergency_stop_in,
    input wire axis_stop_pkg::axis_cmd_t [axis_stop_pkg::num_axes-1:0] axis_cmd,
    input wire logic [axis_stop_pkg::num_axes-1:0] axis_done,
    input wire logic group_start_line_in,
    output logic group_start_line_out,
    output logic group_start_line_oe_n,
    input wire logic group_stop_line_in,
    output logic group_stop_line_out,
    output logic group_stop_line_oe_n,
    input wire logic [axis_stop_pkg::addr_w-1:0] reg_addr,
    input wire logic [axis_stop_pkg::data_w-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [axis_stop_pkg::data_w-1:0] reg_rdata,
    output axis_stop_pkg::axis_state_t [axis_stop_pkg::num_axes-1:0] axis_state,
    output logic irq
);
    localparam int n = axis_stop_pkg::num_axes;
    localparam int dw = axis_stop_pkg::data_w;
    localparam int iw = axis_stop_pkg::irq_w;

    logic [4:0] pin_meta_reg [n];
    logic [4:0] pin_sync_reg [n];
    logic [4:0] pin_prev_reg [n];
    logic [2:0] glb_meta_reg;
    logic [2:0] glb_sync_reg;
    logic emg_prev_reg;
    logic gstop_prev_reg;
    logic [dw-1:0] polarity_reg;
    logic [dw-1:0] mode_reg;
    logic [iw-1:0] irq_status_reg;
    logic [iw-1:0] irq_mask_reg;
    logic [1:0] group_ctrl_reg;
    logic [dw-1:0] rdata_reg;
    logic [n-1:0] moving_reg;
    logic [n-1:0] dir_neg_reg;
    logic [n-1:0] sd_latch_reg;
    logic [n-1:0] stop_now_reg;
    logic [n-1:0] decel_reg;
    logic [n-1:0] org_edge_reg;
    logic [n-1:0] pel_act;
    logic [n-1:0] nel_act;
    logic [n-1:0] sd_act;
    logic [n-1:0] org_act;
    logic [n-1:0] alm_act;
    logic [n-1:0] org_rise;
    logic [n-1:0] hard_stop;
    logic [n-1:0] soft_stop;
    logic [n-1:0] start_ok;
    logic emg_act;
    logic gstart_act;
    logic gstop_act;
    logic emg_fall;
    logic gstop_fall;
    logic [iw-1:0] irq_event;
    logic [dw-1:0] sub_status;
    logic [dw-1:0] ext_status;
    logic [dw-1:0] rdata_next;

    // two-stage synchronisers for the global pins; first stage read only by second
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            glb_meta_reg <= 3'h7;
            glb_sync_reg <= 3'h7;
        end
        else
        begin
            glb_meta_reg <= {group_stop_line_in, group_start_line_in, emergency_stop_in};
            glb_sync_reg <= glb_meta_reg;
        end
    end

    assign emg_act = ~glb_sync_reg[0];
    assign gstart_act = ~glb_sync_reg[1];
    assign gstop_act = ~glb_sync_reg[2];

    // falling edges of emergency and group stop for the event flags
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            emg_prev_reg <= 1'b0;
            gstop_prev_reg <= 1'b0;
        end
        else
        begin
            emg_prev_reg <= emg_act;
            gstop_prev_reg <= gstop_act;
        end
    end

    assign emg_fall = emg_act & ~emg_prev_reg;
    assign gstop_fall = gstop_act & ~gstop_prev_reg;

    // per-axis synchronisation, polarity and stop decisions
    genvar a;
    generate
        for (a = 0; a < n; a++)
        begin : g_axis
            logic [3:0] pol;
            logic [3:0] md;
            assign pol = polarity_reg[a*axis_stop_pkg::pol_stride +: 4];
            assign md = mode_reg[a*axis_stop_pkg::mode_stride +: 4];

            always_ff @(posedge core_clk or posedge rst)
            begin
                if (rst)
                begin
                    pin_meta_reg[a] <= 5'h00;
                    pin_sync_reg[a] <= 5'h00;
                    pin_prev_reg[a] <= 5'h00;
                end
                else
                begin
                    pin_meta_reg[a] <= axis_pins[a];
                    pin_sync_reg[a] <= pin_meta_reg[a];
                    pin_prev_reg[a] <= pin_sync_reg[a];
                end
            end

            // strap low keeps the raw level, strap high inverts it
            assign pel_act[a] = pin_sync_reg[a][4] ^ limit_polarity_strap[a];
            assign nel_act[a] = pin_sync_reg[a][3] ^ limit_polarity_strap[a];
            // software polarity: bit set means the pin is active low
            assign sd_act[a] = pin_sync_reg[a][2] ^ pol[axis_stop_pkg::pol_sd_bit];
            assign org_act[a] = pin_sync_reg[a][1] ^ pol[axis_stop_pkg::pol_org_bit];
            assign alm_act[a] = pin_sync_reg[a][0] ^ pol[axis_stop_pkg::pol_alm_bit];
            // edge taken after polarity so the active edge is always the rising one
            assign org_rise[a] = org_act[a] & ~(pin_prev_reg[a][1] ^ pol[axis_stop_pkg::pol_org_bit]);

            always_comb
            begin
                hard_stop[a] = emg_act | gstop_act;
                soft_stop[a] = 1'b0;
                if ((pel_act[a] & ~dir_neg_reg[a]) | (nel_act[a] & dir_neg_reg[a]))
                begin
                    if (md[axis_stop_pkg::mode_el_decel_bit])
                        soft_stop[a] = 1'b1;
                    else
                        hard_stop[a] = 1'b1;
                end
                if (alm_act[a])
                begin
                    if (md[axis_stop_pkg::mode_alm_decel_bit])
                        soft_stop[a] = 1'b1;
                    else
                        hard_stop[a] = 1'b1;
                end
            end

            // start refused under emergency stop, group stop or an active alarm
            assign start_ok[a] = ~emg_act & ~gstop_act & ~alm_act[a];

            // slowdown: latched mode holds the trigger until the axis stops
            always_ff @(posedge core_clk or posedge rst)
            begin
                if (rst)
                    sd_latch_reg[a] <= 1'b0;
                else if (sd_act[a] & moving_reg[a])
                    sd_latch_reg[a] <= 1'b1;
                else if (~moving_reg[a])
                    sd_latch_reg[a] <= 1'b0;
            end

            // motion tracking; a stopped axis ignores a start that is refused
            always_ff @(posedge core_clk or posedge rst)
            begin
                if (rst)
                begin
                    moving_reg[a] <= 1'b0;
                    dir_neg_reg[a] <= 1'b0;
                end
                else if (moving_reg[a] & (hard_stop[a] | axis_done[a]))
                    moving_reg[a] <= 1'b0;
                else if (~moving_reg[a] & axis_cmd[a].start_req & start_ok[a])
                begin
                    moving_reg[a] <= 1'b1;
                    dir_neg_reg[a] <= axis_cmd[a].dir_neg;
                end
                else if (~moving_reg[a] & gstart_act & start_ok[a] & group_ctrl_reg[axis_stop_pkg::grp_start_bit])
                    moving_reg[a] <= 1'b1;
            end

            // registered outputs toward the motion core
            always_ff @(posedge core_clk or posedge rst)
            begin
                if (rst)
                begin
                    stop_now_reg[a] <= 1'b0;
                    decel_reg[a] <= 1'b0;
                    org_edge_reg[a] <= 1'b0;
                end
                else
                begin
                    stop_now_reg[a] <= moving_reg[a] & hard_stop[a];
                    decel_reg[a] <= moving_reg[a] & (soft_stop[a] | (md[axis_stop_pkg::mode_sd_latch_bit]
                        ? sd_latch_reg[a] : sd_act[a]));
                    org_edge_reg[a] <= org_rise[a];
                end
            end

            assign axis_state[a] = '{moving: moving_reg[a], stop_now: stop_now_reg[a],
                decel: decel_reg[a], origin_edge: org_edge_reg[a]};
            assign sub_status[a*axis_stop_pkg::sub_stride +: axis_stop_pkg::sub_stride] =
                {2'b00, moving_reg[a], alm_act[a], org_act[a], sd_act[a], nel_act[a], pel_act[a]};
            assign irq_event[axis_stop_pkg::irq_org_base + a] = org_rise[a];
            assign irq_event[axis_stop_pkg::irq_stop_base + a] = moving_reg[a] & hard_stop[a];
        end
    endgenerate

    assign irq_event[axis_stop_pkg::irq_emg_bit] = emg_fall;
    assign irq_event[axis_stop_pkg::irq_group_stop_bit] = gstop_fall;
    assign irq_event[3:2] = 2'b00;
    assign ext_status = {30'h0000_0000, gstop_act, gstart_act};

    // shared lines: drive low only while software asserts; open-drain style
    assign group_start_line_out = 1'b0;
    assign group_stop_line_out = 1'b0;
    assign group_start_line_oe_n = ~group_ctrl_reg[axis_stop_pkg::grp_start_bit];
    assign group_stop_line_oe_n = ~group_ctrl_reg[axis_stop_pkg::grp_stop_bit];

    // configuration registers written by software
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            polarity_reg <= axis_stop_pkg::reset_zero;
            mode_reg <= axis_stop_pkg::reset_zero;
            irq_mask_reg <= iw'(axis_stop_pkg::reset_zero);
            group_ctrl_reg <= 2'b00;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                axis_stop_pkg::reg_polarity: polarity_reg <= reg_wdata;
                axis_stop_pkg::reg_mode: mode_reg <= reg_wdata;
                axis_stop_pkg::reg_irq_mask: irq_mask_reg <= reg_wdata[iw-1:0];
                axis_stop_pkg::reg_group_ctrl: group_ctrl_reg <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // sticky events; a set in the same cycle as a clear wins
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            irq_status_reg <= iw'(axis_stop_pkg::reset_zero);
        else if (reg_wr && reg_addr == axis_stop_pkg::reg_irq_status)
            irq_status_reg <= (irq_status_reg & ~reg_wdata[iw-1:0]) | irq_event;
        else
            irq_status_reg <= irq_status_reg | irq_event;
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // read mux; unmapped addresses read zero
    always_comb
    begin
        rdata_next = axis_stop_pkg::reset_zero;
        unique case (reg_addr)
            axis_stop_pkg::reg_polarity: rdata_next = polarity_reg;
            axis_stop_pkg::reg_mode: rdata_next = mode_reg;
            axis_stop_pkg::reg_sub_status: rdata_next = sub_status;
            axis_stop_pkg::reg_ext_status: rdata_next = ext_status;
            axis_stop_pkg::reg_irq_status: rdata_next = dw'(irq_status_reg);
            axis_stop_pkg::reg_irq_mask: rdata_next = dw'(irq_mask_reg);
            axis_stop_pkg::reg_group_ctrl: rdata_next = dw'(group_ctrl_reg);
            default: rdata_next = axis_stop_pkg::reset_zero;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            rdata_reg <= axis_stop_pkg::reset_zero;
        else if (reg_rd)
            rdata_reg <= rdata_next;
        else
            rdata_reg <= axis_stop_pkg::reset_zero;
    end

    assign reg_rdata = rdata_reg;
endmodule : axis_limit_stop_inputs

// ---- axis_limit_stop_inputs_props.sv ----
// concurrent checks on the stop and limit input block
// assumes it is bound to the block top and sees its ports only
`timescale 1ns/10ps
module stop_props (
    input wire logic core_clk,
    input wire logic rst,
    input wire axis_stop_pkg::axis_pins_t [3:0] axis_pins,
    input wire logic [3:0] limit_polarity_strap,
    input wire logic emergency_stop_in,
    input wire axis_stop_pkg::axis_cmd_t [3:0] axis_cmd,
    input wire logic group_stop_line_in,
    input wire logic group_start_line_oe_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire axis_stop_pkg::axis_state_t [3:0] axis_state
);
    logic [31:0] pol_reg;
    logic [1:0] dir_reg;
    logic [3:0] mv;
    logic pa0;
    logic na1;
    logic al2;
    logic og0;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // shadow of the software polarity word
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pol_reg <= 32'h0000_0000;
        end
        else if (reg_wr && reg_addr == axis_stop_pkg::reg_polarity)
        begin
            pol_reg <= reg_wdata;
        end
    end
    // feed direction as last commanded; refused starts are not filtered out
    always_ff @(posedge core_clk)
    begin
        dir_reg[0] <= axis_cmd[0].start_req ? axis_cmd[0].dir_neg : dir_reg[0];
        dir_reg[1] <= axis_cmd[1].start_req ? axis_cmd[1].dir_neg : dir_reg[1];
    end
    // active levels seen at the pins
    assign mv = {axis_state[3].moving, axis_state[2].moving, axis_state[1].moving, axis_state[0].moving};
    assign pa0 = axis_pins[0].pos_end_limit_in ^ limit_polarity_strap[0];
    assign na1 = axis_pins[1].neg_end_limit_in ^ limit_polarity_strap[1];
    assign al2 = axis_pins[2].alarm_in ^ pol_reg[10];
    assign og0 = axis_pins[0].origin_in ^ pol_reg[1];
    AST_EMG_HALT: assert property ((!emergency_stop_in) [*4] |-> mv == 4'h0)
        else $error("axis moving under emergency stop");
    AST_GRP_HALT: assert property ((!group_stop_line_in) [*4] |-> mv == 4'h0)
        else $error("axis moving under group stop");
    AST_POS_STOP: assert property (
        $rose(pa0) && axis_state[0].moving && !dir_reg[0] |-> ##[1:4] (!axis_state[0].moving || axis_state[0].decel))
        else $error("positive limit ignored");
    AST_NEG_STOP: assert property (
        $rose(na1) && axis_state[1].moving && dir_reg[1] |-> ##[1:4] (!axis_state[1].moving || axis_state[1].decel))
        else $error("negative limit ignored");
    AST_ALM_STOP: assert property (al2 [*4] |-> !axis_state[2].moving || axis_state[2].decel)
        else $error("alarm ignored");
    AST_STOP_PULSE: assert property (
        axis_state[0].stop_now |-> (!axis_state[0].moving && $past(axis_state[0].moving)) ##1 !axis_state[0].stop_now)
        else $error("stop pulse malformed");
    AST_ORG_EDGE: assert property (axis_state[0].origin_edge |-> $past(og0, 2) ##1 !axis_state[0].origin_edge)
        else $error("origin edge without active origin");
    AST_GRP_DRIVE: assert property (
        reg_wr && reg_addr == axis_stop_pkg::reg_group_ctrl |=> group_start_line_oe_n == !$past(reg_wdata[0]))
        else $error("start line drive not from control bit");
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside read slot");
    cover property (axis_state[0].stop_now);
    cover property (axis_state[0].origin_edge);
    cover property (axis_state[1].decel && axis_state[1].moving);
endmodule : stop_props
bind axis_limit_stop_inputs stop_props chk_u (
    .core_clk(core_clk), .rst(rst), .axis_pins(axis_pins), .limit_polarity_strap(limit_polarity_strap),
    .emergency_stop_in(emergency_stop_in), .axis_cmd(axis_cmd), .group_stop_line_in(group_stop_line_in),
    .group_start_line_oe_n(group_start_line_oe_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .axis_state(axis_state)
);

// ---- axis_sensor_model.sv ----
// switches, sensors and a peer controller on the block's pins
// assumes the bench gives active flags; pins come out at wire level
`timescale 1ns/10ps
module axis_sensor_model (
    input wire axis_stop_pkg::axis_pins_t [3:0] act,
    input wire logic [3:0] strap,
    input wire logic [31:0] pol,
    input wire logic peer_stop,
    input wire logic sta_out,
    input wire logic sta_oe_n,
    input wire logic stp_out,
    input wire logic stp_oe_n,
    output axis_stop_pkg::axis_pins_t [3:0] pins,
    output logic sta_line,
    output logic stp_line
);
    // strap or polarity bit turns an active switch into its pin level
    always_comb
    begin
        for (int a = 0; a < 4; a++)
        begin
            pins[a].pos_end_limit_in = act[a].pos_end_limit_in ^ strap[a];
            pins[a].neg_end_limit_in = act[a].neg_end_limit_in ^ strap[a];
            pins[a].slowdown_in = act[a].slowdown_in ^ pol[4*a];
            pins[a].origin_in = act[a].origin_in ^ pol[4*a+1];
            pins[a].alarm_in = act[a].alarm_in ^ pol[4*a+2];
        end
    end
    // pulled-up shared lines, low while any controller drives
    assign sta_line = sta_oe_n | sta_out;
    assign stp_line = (stp_oe_n | stp_out) & !peer_stop;
endmodule : axis_sensor_model

// ---- axis_limit_stop_inputs_bench.sv ----
// self-checking bench for the stop and limit input block
// assumes the sensor model on the pins; the bench plays host and motion core
`timescale 1ns/10ps
module axis_limit_stop_inputs_bench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    axis_stop_pkg::axis_pins_t [3:0] act = '0;
    axis_stop_pkg::axis_pins_t [3:0] pins;
    axis_stop_pkg::axis_cmd_t [3:0] cmd = '0;
    axis_stop_pkg::axis_state_t [3:0] st;
    logic [3:0] done = 4'h0;
    logic [31:0] pol = 32'h0000_0000;
    logic emg = 1'b1;
    logic p_stp = 1'b0;
    logic sta_line, sta_out, sta_oe_n, stp_line, stp_out, stp_oe_n, irq;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata;
    int mismatches = 0;
    int tests_run = 0;
    int stop_cnt = 0;
    int org_cnt = 0;
    int org_mark = 0;
    // count one-cycle pulses of axis 0 so no check can miss them between samples
    always @(posedge core_clk)
    begin
        stop_cnt <= stop_cnt + int'(st[0].stop_now);
        org_cnt <= org_cnt + int'(st[0].origin_edge);
    end
    // 100 MHz reference clock
    always #5 core_clk = ~core_clk;
    axis_limit_stop_inputs dut_u (
        .core_clk(core_clk), .rst(rst), .axis_pins(pins), .limit_polarity_strap(4'h5),
        .emergency_stop_in(emg), .axis_cmd(cmd), .axis_done(done),
        .group_start_line_in(sta_line), .group_start_line_out(sta_out), .group_start_line_oe_n(sta_oe_n),
        .group_stop_line_in(stp_line), .group_stop_line_out(stp_out), .group_stop_line_oe_n(stp_oe_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .axis_state(st), .irq(irq)
    );
    axis_sensor_model model_u (
        .act(act), .strap(4'h5), .pol(pol), .peer_stop(p_stp), .sta_out(sta_out), .sta_oe_n(sta_oe_n),
        .stp_out(stp_out), .stp_oe_n(stp_oe_n), .pins(pins), .sta_line(sta_line), .stp_line(stp_line)
    );
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic tk(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tk
    // bus strobes drop after one cycle and leave a gap, so no signal is set twice at once
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        tk(1);
        reg_wr <= 1'b0;
        tk(1);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tk(1);
        reg_rd <= 1'b0;
        chk("reg_rdata", reg_rdata, exp);
        tk(1);
    endtask : rd
    task automatic go(input int a, input logic dir);
        cmd[a] <= {1'b1, dir};
        tk(1);
        cmd[a] <= 2'b00;
        tk(1);
    endtask : go
    task automatic end_of_test();
        if (mismatches == 0 && tests_run > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    // cut a hang short; the sequence needs well under 1000 cycles
    initial
    begin
        repeat (3000) @(posedge core_clk);
        mismatches++;
        end_of_test();
    end
    // main sequence
    initial
    begin
        tk(6);
        rst <= 1'b0;
        tk(3);
        for (int a = 0; a < 16; a++) rd(a[3:0], 32'h0000_0000);
        act <= {4{5'h1f}};
        tk(5);
        rd(4'h2, 32'h1f1f_1f1f);
        pol <= 32'h0000_7777;
        wr(4'h0, 32'h0000_7777);
        tk(4);
        rd(4'h2, 32'h1f1f_1f1f);
        act <= '0;
        tk(4);
        wr(4'h4, 32'h0000_0fff);
        go(0, 1'b0);
        rd(4'h2, 32'h0000_0020);
        act[0].pos_end_limit_in <= 1'b1;
        tk(6);
        rd(4'h2, 32'h0000_0001);
        rd(4'h4, 32'h0000_0100);
        wr(4'h5, 32'h0000_0100);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(4'h4, 32'h0000_0100);
        chk("irq", {31'h0, irq}, 32'h0);
        act[0].pos_end_limit_in <= 1'b0;
        // axis 1 decelerates on limits; a positive limit must not stop a negative feed
        wr(4'h1, 32'h0000_0020);
        go(1, 1'b1);
        act[1].pos_end_limit_in <= 1'b1;
        tk(6);
        rd(4'h2, 32'h0000_2100);
        act[1].neg_end_limit_in <= 1'b1;
        tk(6);
        chk("decel", {31'h0, st[1].decel}, 32'h1);
        rd(4'h2, 32'h0000_2300);
        done[1] <= 1'b1;
        tk(1);
        done[1] <= 1'b0;
        tk(3);
        rd(4'h2, 32'h0000_0300);
        act <= '0;
        wr(4'h4, 32'h0000_0fff);
        go(2, 1'b0);
        act[2].alarm_in <= 1'b1;
        tk(6);
        rd(4'h2, 32'h0010_0000);
        rd(4'h4, 32'h0000_0400);
        act <= '0;
        // axis 3 slowdown latched, axis 2 level; axis 2 alarm decelerates
        wr(4'h1, 32'h0000_1400);
        go(2, 1'b0);
        go(3, 1'b0);
        act[2].slowdown_in <= 1'b1;
        act[3].slowdown_in <= 1'b1;
        tk(5);
        chk("decel", {30'h0, st[3].decel, st[2].decel}, 32'h3);
        act <= '0;
        tk(5);
        chk("decel", {30'h0, st[3].decel, st[2].decel}, 32'h2);
        done <= 4'hc;
        tk(1);
        done <= 4'h0;
        tk(3);
        // alarm in decelerate mode keeps the axis moving with decel raised
        go(2, 1'b0);
        act[2].alarm_in <= 1'b1;
        tk(6);
        chk("decel", {30'h0, st[2].moving, st[2].decel}, 32'h3);
        act <= '0;
        done <= 4'h4;
        tk(1);
        done <= 4'h0;
        tk(3);
        wr(4'h4, 32'h0000_0fff);
        org_mark = org_cnt;
        act[0].origin_in <= 1'b1;
        tk(6);
        rd(4'h4, 32'h0000_0010);
        wr(4'h4, 32'h0000_0fff);
        tk(6);
        rd(4'h4, 32'h0000_0000);
        chk("origin_edge", org_cnt - org_mark, 32'h1);
        act <= '0;
        go(0, 1'b0);
        go(1, 1'b0);
        rd(4'h2, 32'h0000_2020);
        emg <= 1'b0;
        tk(6);
        rd(4'h2, 32'h0000_0000);
        rd(4'h4, 32'h0000_0301);
        go(2, 1'b0);
        tk(2);
        rd(4'h2, 32'h0000_0000);
        emg <= 1'b1;
        tk(4);
        wr(4'h6, 32'h0000_0001);
        tk(4);
        chk("oe_n", {31'h0, sta_oe_n}, 32'h0);
        rd(4'h3, 32'h0000_0001);
        rd(4'h2, 32'h2020_2020);
        wr(4'h6, 32'h0000_0000);
        p_stp <= 1'b1;
        tk(6);
        rd(4'h3, 32'h0000_0002);
        rd(4'h2, 32'h0000_0000);
        rd(4'h4, 32'h0000_0f03);
        p_stp <= 1'b0;
        tk(2);
        // own drive of the stop line; both line outputs only ever pull low
        wr(4'h6, 32'h0000_0002);
        tk(4);
        chk("oe_n", {30'h0, stp_oe_n, sta_oe_n}, 32'h1);
        chk("line_out", {30'h0, stp_out, sta_out}, 32'h0);
        rd(4'h3, 32'h0000_0002);
        wr(4'h6, 32'h0000_0000);
        tk(4);
        chk("stop_now", stop_cnt, 32'h3);
        end_of_test();
    end
endmodule : axis_limit_stop_inputs_bench
